// >>> design/mstw_pkg.sv
// Purpose: Shared constants and types for the axis main status word block
// Assumes: 250 MHz system clock
// Notes:   Offsets are indices on the plain register port
package mstw_pkg;

	// Register port geometry
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;

	// Register offsets
	localparam logic [3:0] OFF_MAIN_STATUS  = 4'h0;
	localparam logic [3:0] OFF_CONFIG       = 4'h1;
	localparam logic [3:0] OFF_COMMAND      = 4'h2;
	localparam logic [3:0] OFF_MODE         = 4'h3;
	localparam logic [3:0] OFF_MOVE_AMOUNT  = 4'h4;
	localparam logic [3:0] OFF_ERROR_CAUSE  = 4'h5;
	localparam logic [3:0] OFF_EVENT_CAUSE  = 4'h6;

	// Main status bit positions
	localparam int BIT_START   = 0;
	localparam int BIT_RUN     = 1;
	localparam int BIT_STOPIRQ = 2;
	localparam int BIT_STOPPED = 3;
	localparam int BIT_ERRIRQ  = 4;
	localparam int BIT_EVTIRQ  = 5;
	localparam int BIT_SEQ_LO  = 6;
	localparam int BIT_CMP_LO  = 8;
	localparam int BIT_OVR     = 13;
	localparam int BIT_OPPRE   = 14;
	localparam int BIT_CMPPRE  = 15;

	// Config register fields
	localparam int CFG_STOP_IRQ_EN = 0;
	localparam int CFG_CLEAR_MODE  = 1;

	// Mode register fields
	localparam int MODE_SEQ_LO = 8;

	// Command codes
	localparam logic [7:0] CMD_START_FL   = 8'h50;
	localparam logic [7:0] CMD_START_UD   = 8'h53;
	localparam logic [7:0] CMD_STOP       = 8'h49;
	localparam logic [7:0] CMD_SLOW_STOP  = 8'h4a;
	localparam logic [7:0] CMD_STOP_FLAG_RESET = 8'h2d;
	localparam logic [7:0] CMD_OVR_FLAG_RESET  = 8'h2e;

	// Operation modes
	localparam logic [6:0] MODE_CMD_CONT    = 7'h00;
	localparam logic [6:0] MODE_PULSER_CONT = 7'h01;
	localparam logic [6:0] MODE_SWITCH_CONT = 7'h02;

	// Reset values
	localparam logic [15:0] RST_CONFIG = 16'h0001;
	localparam logic [15:0] RST_MODE   = 16'h0000;

	// Timing
	localparam int CLK_PERIOD_PS    = 4000;
	localparam int BUSY_ON_DELAY_NS = 8;
	localparam int START_DELAY_NS   = 12;
	localparam int BUSY_ON_CYC  = (BUSY_ON_DELAY_NS * 1000) / CLK_PERIOD_PS;
	localparam int START_CYC    = (START_DELAY_NS * 1000) / CLK_PERIOD_PS;
	localparam int READ_CLR_CYC = 3;

	// Register port request
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} mstw_req_t;

	// Live inputs from the motion core
	typedef struct packed {
		logic [4:0] cmp_hit;
		logic       op_prereg_full;
		logic       cmp_prereg_full;
		logic       motion_done;
	} mstw_live_t;

endpackage

// >>> design/mstw_main_status.sv
// Purpose: Per-axis main status word with start/run sequencing and flags
// Assumes: Host port strobes are synchronous one-cycle pulses
// Notes:   Pulse generator itself lives elsewhere; motion_done ends a run
//
// How it works
// - Start bit sets on start command write
// - Run bit mirrors busy, busy low running
// - Stop irq flag gated by its enable
// - Stop flag clears read+3 or reset command
// - Stopped bit sets on run fall
// - Error flag follows error cause register
// - Event flag follows event cause register
// - Bits 7:6 show mode sequence number
// - Bits 8..12 show comparator hits
// - Override flag updated on move write
// - Override flag clears read+3 or command
// - Bit 14 shows operation pre-register full
// - Bit 15 shows compare pre-register full
// - Stop flag one cycle after run falls
// - Command mode run within busy-on delay
// - Pulser mode run within busy-on delay
// - Switch mode run within busy-on delay
// - Switch mode pulse within start delay
// - Status snapshot refreshed only while not reading
`timescale 1ns/10ps
module mstw_main_status (
	// Clock and reset
	input  wire logic                   clock_in,
	input  wire logic                   nrst_in,
	// Register port
	input  wire mstw_pkg::mstw_req_t    req_in,
	output logic [mstw_pkg::DATA_W-1:0] rdata_out,
	// Motion core status
	input  wire mstw_pkg::mstw_live_t   live_in,
	input  wire logic                   pulser_phase_a_in,
	input  wire logic                   direction_switch_in,
	// Pins
	output logic                        busy_out,
	output logic                        int_n_out,
	output logic                        pulse_out
);
	import mstw_pkg::*;

	// Operating notes
	// Status word is a 16-bit view of one axis
	// Host reads it through a frozen snapshot
	// Snapshot refreshes only while read strobe low
	// Back-to-back reads therefore return one stale word
	// Hence hosts leave an idle cycle between polls
	//
	// Start sequencing
	// Start command sets the start-written flag
	// Codes in the start window are all accepted
	// Stop and slow-stop both end the run at once
	// Slow stop has no ramp here; pulse core owns that
	// Launch counter waits out the busy-on delay
	// Counter restarts whenever the trigger drops
	// Trigger source depends on the operation mode
	// Command mode: start flag alone launches
	// Pulser mode: start flag plus phase-A level
	// Switch mode: start flag plus direction switch
	// Unknown modes fall back to command behaviour
	//
	// Run end
	// Motion core raises motion_done to end a run
	// A one-cycle pulse is enough; level also works
	// Fall of the run flag is seen one cycle later
	// That fall sets the stopped flag
	// It also sets the stop flag when enabled
	// Start-written flag drops on the same fall
	// A start in the fall cycle keeps the flag set
	//
	// Stop interrupt flag
	// Enable cleared forces the flag low at once
	// Clear mode 0: read arms a three-cycle clear
	// Clear mode 1: only the reset command clears
	// A new stop in the clear cycle wins
	// Read that sees the flag low arms nothing
	//
	// Override-late flag
	// Move write while stopped marks a late override
	// Move write while running clears the mark
	// Same clear modes as the stop flag
	// Move write in the clear cycle wins
	//
	// Cause registers
	// Error causes clear by writing ones
	// Nothing in this block sets a cause bit
	// Setting logic belongs to the fault detectors
	// Event causes have no source here and read zero
	// Either register nonzero pulls the interrupt pin
	//
	// Live bits
	// Comparator hits pass straight through
	// Pre-register full bits pass straight through
	// These follow their sources even in reset
	// Sequence field copies mode bits 9:8
	// Sequence value never affects motion
	//
	// Pins
	// Busy pin is registered, one cycle behind run
	// Interrupt pin is registered and active low
	// First switch-mode pulse comes from a counter
	// Later pulses belong to the pulse generator
	//
	// Read port
	// Read data stands for one cycle only
	// All other cycles drive zero on read data
	// Unmapped offsets read zero
	// Writes to unmapped offsets are ignored
	// Writes to the status offset are ignored
	//
	// Limitations
	// No bus wait states; every strobe is taken
	// Strobes are assumed one cycle wide
	// Wider read strobes stall the snapshot longer
	// Pin inputs are assumed already synchronous
	// No filter on phase-A or direction inputs
	// Trade-off: snapshot costs one cycle of age
	// In return a read never sees a torn word
	//
	// Reset
	// All flags and counters clear on reset
	// Config returns with the stop flag enabled
	// Busy pin idles high, interrupt pin idles high
	// Snapshot and read data clear to zero
	//
	// Timing summary
	// Start write to start flag: one cycle
	// Start flag to run: busy-on delay in cycles
	// Run to busy pin: one more cycle
	// Run fall to stop flag: one cycle
	// Stop flag to interrupt pin: one cycle
	// Read to flag clear: three cycles

	logic [15:0] config_reg;
	logic [15:0] mode_reg;
	logic [15:0] error_cause_reg;
	logic [15:0] event_cause_reg;
	logic        start_written_flag;
	logic        running_flag;
	logic        stopped_flag;
	logic        stop_irq_flag;
	logic        override_late_flag;
	logic [2:0]  launch_cnt;
	logic [2:0]  pulse_cnt;
	logic        pulse_pend;
	logic [3:0]  stop_rd_sh;
	logic [3:0]  ovr_rd_sh;
	logic [15:0] main_status_word;
	logic [15:0] snap;
	logic        rd_d;

	// Decode a write to a given offset
	function automatic logic wr_at(input mstw_req_t r, input logic [3:0] off);
		return r.wr && (r.addr == off);
	endfunction

	logic cmd_wr;
	logic start_cmd;
	logic stop_cmd;
	logic stat_rd;
	logic run_fall;
	logic launch_trig;
	logic [6:0] op_mode;
	assign cmd_wr    = wr_at(req_in, OFF_COMMAND);
	assign start_cmd = cmd_wr && req_in.wdata[7:0] >= CMD_START_FL
		&& req_in.wdata[7:0] <= CMD_START_UD;
	assign stop_cmd  = cmd_wr && (req_in.wdata[7:0] == CMD_STOP
		|| req_in.wdata[7:0] == CMD_SLOW_STOP);
	assign stat_rd   = req_in.rd && (req_in.addr == OFF_MAIN_STATUS);
	assign op_mode   = mode_reg[6:0];

	// Launch condition per operation mode
	always_comb begin
		case (op_mode)
			MODE_PULSER_CONT: launch_trig = start_written_flag && pulser_phase_a_in;
			MODE_SWITCH_CONT: launch_trig = start_written_flag && direction_switch_in;
			default:          launch_trig = start_written_flag;
		endcase
	end

	// Software-written registers
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			config_reg      <= RST_CONFIG;
			mode_reg        <= RST_MODE;
			error_cause_reg <= 16'h0000;
			event_cause_reg <= 16'h0000;
		end else begin
			if (wr_at(req_in, OFF_CONFIG))
				config_reg <= req_in.wdata;
			if (wr_at(req_in, OFF_MODE))
				mode_reg <= req_in.wdata;
			// Error causes clear by writing ones; any event cause write clears all
			if (wr_at(req_in, OFF_ERROR_CAUSE))
				error_cause_reg <= error_cause_reg & ~req_in.wdata;
			if (wr_at(req_in, OFF_EVENT_CAUSE))
				event_cause_reg <= 16'h0000;
		end
	end

	// Start-written flag: set by start, dropped when run ends
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in)
			start_written_flag <= 1'b0;
		else if (start_cmd)
			start_written_flag <= 1'b1;
		else if (run_fall || stop_cmd)
			start_written_flag <= 1'b0;
	end

	// Busy-on launch counter; counts up while the trigger holds
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			running_flag <= 1'b0;
			launch_cnt   <= 3'h0;
		end else if (running_flag) begin
			if (live_in.motion_done || stop_cmd)
				running_flag <= 1'b0;
		end else if (launch_trig && !stop_cmd) begin
			if (launch_cnt == 3'(BUSY_ON_CYC - 1)) begin
				running_flag <= 1'b1;
				launch_cnt   <= 3'h0;
			end else
				launch_cnt <= launch_cnt + 3'h1;
		end else
			launch_cnt <= 3'h0;
	end

	// Previous run level for fall detection
	logic run_d;
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in)
			run_d <= 1'b0;
		else
			run_d <= running_flag;
	end
	assign run_fall = run_d && !running_flag;

	// First output pulse in switch mode within start delay
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			pulse_cnt  <= 3'h0;
			pulse_pend <= 1'b0;
			pulse_out  <= 1'b0;
		end else begin
			pulse_out <= 1'b0;
			if (!pulse_pend && !running_flag && op_mode == MODE_SWITCH_CONT
				&& start_written_flag && direction_switch_in) begin
				pulse_pend <= 1'b1;
				pulse_cnt  <= 3'h0;
			end else if (pulse_pend) begin
				if (pulse_cnt == 3'(START_CYC - 1)) begin
					pulse_out  <= 1'b1;
					pulse_pend <= 1'b0;
				end else
					pulse_cnt <= pulse_cnt + 3'h1;
			end
		end
	end

	// Stopped flag: set on run fall, cleared by start
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in)
			stopped_flag <= 1'b0;
		else if (run_fall)
			stopped_flag <= 1'b1;
		else if (start_cmd)
			stopped_flag <= 1'b0;
	end

	// Read-clear delay lines; a read arms a three-cycle clear
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			stop_rd_sh <= 4'h0;
			ovr_rd_sh  <= 4'h0;
		end else begin
			stop_rd_sh <= {stop_rd_sh[2:0], stat_rd && stop_irq_flag};
			ovr_rd_sh  <= {ovr_rd_sh[2:0], stat_rd && override_late_flag};
		end
	end

	// Stop interrupt flag; set wins over read and command clears
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in)
			stop_irq_flag <= 1'b0;
		else if (!config_reg[CFG_STOP_IRQ_EN])
			stop_irq_flag <= 1'b0;
		else if (run_fall)
			stop_irq_flag <= 1'b1;
		else if (!config_reg[CFG_CLEAR_MODE] && stop_rd_sh[READ_CLR_CYC-1])
			stop_irq_flag <= 1'b0;
		else if (config_reg[CFG_CLEAR_MODE] && cmd_wr
			&& req_in.wdata[7:0] == CMD_STOP_FLAG_RESET)
			stop_irq_flag <= 1'b0;
	end

	// Override-late flag, updated on move amount write
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in)
			override_late_flag <= 1'b0;
		else if (wr_at(req_in, OFF_MOVE_AMOUNT))
			override_late_flag <= !running_flag;
		else if (!config_reg[CFG_CLEAR_MODE] && ovr_rd_sh[READ_CLR_CYC-1])
			override_late_flag <= 1'b0;
		else if (config_reg[CFG_CLEAR_MODE] && cmd_wr
			&& req_in.wdata[7:0] == CMD_OVR_FLAG_RESET)
			override_late_flag <= 1'b0;
	end

	// Comparator mirrors, one live bit per comparator
	logic [4:0] cmp_mirror;
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_cmp
			assign cmp_mirror[gi] = live_in.cmp_hit[gi];
		end
	endgenerate

	// Assemble the live status word
	always_comb begin
		main_status_word                  = 16'h0000;
		main_status_word[BIT_START]       = start_written_flag;
		main_status_word[BIT_RUN]         = running_flag;
		main_status_word[BIT_STOPIRQ]     = stop_irq_flag;
		main_status_word[BIT_STOPPED]     = stopped_flag;
		main_status_word[BIT_ERRIRQ]      = |error_cause_reg;
		main_status_word[BIT_EVTIRQ]      = |event_cause_reg;
		main_status_word[BIT_SEQ_LO+:2]   = mode_reg[MODE_SEQ_LO+:2];
		main_status_word[BIT_CMP_LO+:5]   = cmp_mirror;
		main_status_word[BIT_OVR]         = override_late_flag;
		main_status_word[BIT_OPPRE]       = live_in.op_prereg_full;
		main_status_word[BIT_CMPPRE]      = live_in.cmp_prereg_full;
	end

	// Snapshot frozen during a read so the host sees a stable word
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			snap <= 16'h0000;
			rd_d <= 1'b0;
		end else begin
			rd_d <= req_in.rd;
			if (!req_in.rd)
				snap <= main_status_word;
		end
	end

	// Read data, one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in)
			rdata_out <= 16'h0000;
		else if (req_in.rd) begin
			case (req_in.addr)
				OFF_MAIN_STATUS: rdata_out <= snap;
				OFF_CONFIG:      rdata_out <= config_reg;
				OFF_MODE:        rdata_out <= mode_reg;
				OFF_ERROR_CAUSE: rdata_out <= error_cause_reg;
				OFF_EVENT_CAUSE: rdata_out <= event_cause_reg;
				default:         rdata_out <= 16'h0000;
			endcase
		end else
			rdata_out <= 16'h0000;
	end

	// Pins: busy low while running; interrupt low on stop flag or any cause bit
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			busy_out  <= 1'b1;
			int_n_out <= 1'b1;
		end else begin
			busy_out  <= !running_flag;
			int_n_out <= !(stop_irq_flag || (|error_cause_reg)
				|| (|event_cause_reg));
		end
	end

endmodule

// >>> testbench/mstw_main_status_properties.sv
// Purpose: Port-level checks on the axis main status word
// Assumes: Config and mode are shadowed from host writes
// Notes:   Run start windows allow one extra cycle for the registered busy pin; the command window one more for the start flag
`timescale 1ns/10ps
module mstw_main_status_properties (
	// Clock and reset
	input wire logic                   clock_in,
	input wire logic                   nrst_in,
	// Register port
	input wire mstw_pkg::mstw_req_t    req_in,
	input wire logic [15:0]            rdata_out,
	// Motion core status
	input wire mstw_pkg::mstw_live_t   live_in,
	input wire logic                   pulser_phase_a_in,
	input wire logic                   direction_switch_in,
	// Pins
	input wire logic                   busy_out,
	input wire logic                   int_n_out,
	input wire logic                   pulse_out
);
	import mstw_pkg::*;
	localparam int CMD_MAX = BUSY_ON_CYC + 2;
	localparam int IN_MAX  = BUSY_ON_CYC + 1;
	localparam int PLS_MAX = START_CYC + 1;
	logic [15:0] cfg;
	logic [15:0] mode;
	default clocking @(posedge clock_in); endclocking
	default disable iff (!nrst_in);
	// Shadow of config and mode, gating the checks and giving the expected sequence field
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			cfg  <= RST_CONFIG;
			mode <= RST_MODE;
		end else if (req_in.wr && req_in.addr == OFF_CONFIG) begin
			cfg <= req_in.wdata;
		end else if (req_in.wr && req_in.addr == OFF_MODE) begin
			mode <= req_in.wdata;
		end
	end
	// Status read with settled inputs, so the snapshot lag does not matter
	sequence quiet_rd;
		req_in.rd && req_in.addr == OFF_MAIN_STATUS && !$past(req_in.rd) && $past(nrst_in, 3)
			&& $stable(live_in) && $past($stable(live_in)) && $stable(mode)
			&& $past($stable(mode)) && $stable(cfg) && $past($stable(cfg));
	endsequence
	sequence idle_in(logic [6:0] m);
		busy_out && !live_in.motion_done && mode[6:0] == m;
	endsequence
	cmp_bits_a: assert property (quiet_rd |=> rdata_out[12:8] == $past(live_in.cmp_hit))
		else $error("comparator bits wrong");
	prereg_bits_a: assert property (quiet_rd |=>
		rdata_out[15:14] == $past({live_in.cmp_prereg_full, live_in.op_prereg_full}))
		else $error("pre-register bits wrong");
	seq_field_a: assert property (quiet_rd |=> rdata_out[7:6] == $past(mode[9:8]))
		else $error("sequence field wrong");
	irq_mask_a: assert property (quiet_rd ##0 !cfg[0] |=> !rdata_out[2])
		else $error("stop flag set while disabled");
	cmd_start_a: assert property (idle_in(MODE_CMD_CONT) && req_in.wr &&
		req_in.addr == OFF_COMMAND && req_in.wdata[7:0] inside {[8'h50:8'h53]}
		|-> ##[1:CMD_MAX] !busy_out) else $error("command start too slow");
	pulser_start_a: assert property (idle_in(MODE_PULSER_CONT) &&
		$rose(pulser_phase_a_in) |-> ##[1:IN_MAX] !busy_out) else $error("pulser start slow");
	switch_start_a: assert property (idle_in(MODE_SWITCH_CONT) &&
		$rose(direction_switch_in) |-> ##[1:IN_MAX] !busy_out) else $error("switch start slow");
	first_pulse_a: assert property (idle_in(MODE_SWITCH_CONT) &&
		$rose(direction_switch_in) |-> ##[1:PLS_MAX] pulse_out) else $error("no first pulse");
	pulse_width_a: assert property (pulse_out |=> !pulse_out)
		else $error("pulse longer than one cycle");
	stop_int_a: assert property ($rose(busy_out) && cfg[0] |-> ##[0:1] !int_n_out)
		else $error("stop interrupt late");
endmodule
bind mstw_main_status mstw_main_status_properties u_props (.clock_in, .nrst_in, .req_in,
	.rdata_out, .live_in, .pulser_phase_a_in, .direction_switch_in, .busy_out, .int_n_out,
	.pulse_out);

// >>> testbench/mstw_host_model.sv
// Purpose: Host processor polling and writing the status block
// Assumes: Slave never stalls; read data stands one cycle
// Notes:   Reads leave idle cycles so the snapshot can refresh
`timescale 1ns/10ps
module mstw_host_model (
	// Clock and read data
	input  wire logic        clock_in,
	input  wire logic [15:0] rdata_in,
	// Register port request
	output mstw_pkg::mstw_req_t req_out
);
	import mstw_pkg::*;
	initial req_out = '0;
	// One-cycle write strobe
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock_in);
		req_out <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock_in);
		req_out.wr <= 1'b0;
	endtask
	// Data taken at the edge closing the answer cycle
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clock_in);
		req_out <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clock_in);
		req_out.rd <= 1'b0;
		@(posedge clock_in);
		d = rdata_in;
	endtask
endmodule

// >>> testbench/mstw_main_status_tb.sv
// Purpose: Self-checking bench for the axis main status word
// Assumes: Motion core is mimicked by live and pin inputs
// Notes:   Seeded random live status and sequence numbers
`timescale 1ns/10ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin n_fail++; $display("Error %s exp %h got %h", n, e, s); end end
module mstw_main_status_tb;
	import mstw_pkg::*;
	logic              clock_in = 1'b0;
	logic              nrst_in = 1'b0;
	logic              pa = 1'b0;
	logic              dsw = 1'b0;
	logic [1:0]        seq = 2'h0;
	logic [15:0]       d, rdata;
	logic              busy, int_n, pulse;
	mstw_live_t        live;
	mstw_req_t         req;
	int                n_fail = 0;
	int                checked = 0;
	int                cyc = 0;
	mstw_main_status dut (.clock_in(clock_in), .nrst_in(nrst_in), .req_in(req),
		.rdata_out(rdata), .live_in(live), .pulser_phase_a_in(pa),
		.direction_switch_in(dsw), .busy_out(busy), .int_n_out(int_n), .pulse_out(pulse));
	mstw_host_model host (.clock_in(clock_in), .rdata_in(rdata), .req_out(req));
	always #2 clock_in = ~clock_in;
	// Hang guard, far above the few hundred cycles needed
	always @(posedge clock_in) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			results();
		end
	end
	function automatic logic [15:0] exp_st(logic [5:0] f, logic ovr);
		return {live.cmp_prereg_full, live.op_prereg_full, ovr, live.cmp_hit, seq, f};
	endfunction
	task automatic st(input logic [5:0] f, input logic ovr);
		host.rd(OFF_MAIN_STATUS, d);
		`CHK("status", exp_st(f, ovr), d)
	endtask
	task automatic mode_set(input logic [6:0] m);
		seq = 2'($urandom);
		host.wr(OFF_MODE, {6'h00, seq, 1'b0, m});
	endtask
	task automatic go(input logic [7:0] c);
		host.wr(OFF_COMMAND, {8'h00, c});
		repeat (5) @(posedge clock_in);
	endtask
	// Motion core reports the end of the move
	task automatic halt;
		live.motion_done <= 1'b1;
		@(posedge clock_in);
		live.motion_done <= 1'b0;
		repeat (3) @(posedge clock_in);
	endtask
	task automatic results;
		if (n_fail == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		void'($urandom(61146));
		live = {7'($urandom), 1'b0};
		repeat (20) @(posedge clock_in);
		nrst_in <= 1'b1;
		st(6'h00, 1'b0);
		host.rd(4'hf, d);
		`CHK("unmapped", 16'h0000, d)
		for (int i = 0; i < 8; i++) begin
			live <= {7'($urandom), 1'b0};
			mode_set(MODE_CMD_CONT);
			repeat (2) @(posedge clock_in);
			st(6'h00, 1'b0);
		end
		go(CMD_START_FL);
		`CHK("busy", 1'b0, busy)
		st(6'h03, 1'b0);
		halt();
		`CHK("int", 1'b0, int_n)
		st(6'h0c, 1'b0);
		repeat (4) @(posedge clock_in);
		st(6'h08, 1'b0);
		host.wr(OFF_CONFIG, 16'h0003);
		for (int i = 0; i < 4; i++) begin
			go(CMD_START_FL + 8'(i));
			st(6'h03, 1'b0);
			if (i % 2 == 0) host.wr(OFF_COMMAND, {8'h00, CMD_STOP});
			else halt();
			repeat (4) @(posedge clock_in);
			st(6'h0c, 1'b0);
			st(6'h0c, 1'b0);
			host.wr(OFF_COMMAND, {8'h00, CMD_STOP_FLAG_RESET});
			st(6'h08, 1'b0);
		end
		host.wr(OFF_CONFIG, 16'h0000);
		go(CMD_START_FL);
		halt();
		st(6'h08, 1'b0);
		`CHK("int", 1'b1, int_n)
		host.wr(OFF_MOVE_AMOUNT, 16'($urandom));
		st(6'h08, 1'b1);
		repeat (4) @(posedge clock_in);
		st(6'h08, 1'b0);
		host.wr(OFF_CONFIG, 16'h0002);
		host.wr(OFF_MOVE_AMOUNT, 16'($urandom));
		st(6'h08, 1'b1);
		st(6'h08, 1'b1);
		host.wr(OFF_COMMAND, {8'h00, CMD_OVR_FLAG_RESET});
		st(6'h08, 1'b0);
		go(CMD_START_FL);
		host.wr(OFF_MOVE_AMOUNT, 16'($urandom));
		st(6'h03, 1'b0);
		halt();
		mode_set(MODE_PULSER_CONT);
		host.wr(OFF_COMMAND, {8'h00, CMD_START_FL});
		pa <= 1'b1;
		repeat (5) @(posedge clock_in);
		`CHK("busy", 1'b0, busy)
		pa <= 1'b0;
		halt();
		`CHK("busy", 1'b1, busy)
		mode_set(MODE_SWITCH_CONT);
		host.wr(OFF_COMMAND, {8'h00, CMD_START_FL});
		dsw <= 1'b1;
		repeat (5) @(posedge clock_in);
		`CHK("busy", 1'b0, busy)
		dsw <= 1'b0;
		halt();
		results();
	end
endmodule
